// file: design/wdt_pkg.sv
// constants and types shared by the watchdog time-out reset block
package wdt_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned MC_CLKS = 12;
	localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);
	localparam int unsigned CNT_BITS_DEF = 14;
	// width of the chip reset pulse, as a least time
	localparam int unsigned RST_HOLD_NS = 600;
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [4:0] RST_HOLD = 5'(RST_HOLD_CYC);

	// register map: printed offsets are indices, byte address is four times that
	localparam int unsigned ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTRL_IDX = 12'h08f;
	localparam logic [ADDR_W-1:0] STAT_IDX = 12'h090;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'(CTRL_IDX * 4);
	localparam logic [ADDR_W-1:0] STAT_ADDR = 12'(STAT_IDX * 4);

	// watchdog_control fields
	localparam int unsigned RUN_EN_BIT = 7;
	localparam int unsigned RESTART_BIT = 6;
	localparam int unsigned IDLE_EN_BIT = 5;
	localparam int unsigned SEL_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] SEL_RESET = 3'h0;

	// status fields
	localparam int unsigned SEEN_BIT = 0;
	localparam int unsigned RUNNING_BIT = 1;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// prescaler code to mask of machine cycles per tick (factor minus one)
	function automatic logic [7:0] wdt_sel_mask(input logic [2:0] sel);
		case (sel)
			3'h0: wdt_sel_mask = 8'h01;
			3'h2: wdt_sel_mask = 8'h03;
			3'h1: wdt_sel_mask = 8'h07;
			3'h3: wdt_sel_mask = 8'h0f;
			3'h4: wdt_sel_mask = 8'h1f;
			3'h5: wdt_sel_mask = 8'h3f;
			3'h6: wdt_sel_mask = 8'h7f;
			default: wdt_sel_mask = 8'hff;
		endcase
	endfunction : wdt_sel_mask
endpackage : wdt_pkg

// file: design/wdt_ctl_if.sv
// control carrier between the watchdog top and its tick and count stages
`timescale 1ns/1ps
`default_nettype none
interface wdt_ctl_if;
	logic run;
	logic clear;
	logic [2:0] sel;
	logic tick;
	logic expire;
	modport top (output run, output clear, output sel, input tick, input expire);
	modport pre (input run, input clear, input sel, output tick);
	modport cnt (input run, input clear, input tick, output expire);
endinterface : wdt_ctl_if
`default_nettype wire

// file: design/wdt_tick.sv
// machine-cycle divider and selectable prescaler of the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdt_tick (
	input wire logic clk_i,
	input wire logic rst_n_i,
	wdt_ctl_if.pre ctl
);
	typedef struct packed {
		logic [3:0] mc;
		logic [7:0] pre;
		logic tick;
	} wdt_tick_st_t;

	wdt_tick_st_t st_ff;
	wdt_tick_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (ctl.clear) begin
			nxt_st.mc = 4'h0;
			nxt_st.pre = 8'h00;
		end else if (ctl.run) begin
			if (st_ff.mc == wdt_pkg::MC_LAST) begin
				nxt_st.mc = 4'h0;
				if ((st_ff.pre & wdt_pkg::wdt_sel_mask(ctl.sel)) == wdt_pkg::wdt_sel_mask(ctl.sel)) begin
					nxt_st.pre = 8'h00;
					nxt_st.tick = 1'b1;
				end else begin
					nxt_st.pre = st_ff.pre + 8'h01;
				end
			end else begin
				nxt_st.mc = st_ff.mc + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ctl.tick = st_ff.tick;
endmodule : wdt_tick
`default_nettype wire

// file: design/wdt_count.sv
// watchdog period counter that flags the end of the period
`timescale 1ns/1ps
`default_nettype none
module wdt_count #(
	parameter int unsigned CNT_BITS = wdt_pkg::CNT_BITS_DEF
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	wdt_ctl_if.cnt ctl
);
	typedef struct packed {
		logic [CNT_BITS-1:0] cnt;
		logic expire;
	} wdt_count_st_t;

	wdt_count_st_t st_ff;
	wdt_count_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.expire = 1'b0;
		if (ctl.clear) begin
			nxt_st.cnt = '0;
		end else if (ctl.run && ctl.tick) begin
			if (&st_ff.cnt) begin
				nxt_st.expire = 1'b1;
			end
			nxt_st.cnt = st_ff.cnt + {{(CNT_BITS-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ctl.expire = st_ff.expire;
endmodule : wdt_count
`default_nettype wire

// file: design/wdt_top.sv
// watchdog time-out reset with its control register on axi4-lite
//
// Behaviour
// - count only while run enable bit set
// - restart bit clears counter, prescaler, self-clears
// - idle enable lets counting continue in idle
// - three-bit select picks divide two to 256
// - period is 2^14 times factor times twelve
// - expiry of enabled watchdog resets the chip
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module wdt_top #(
	parameter int unsigned CNT_BITS = wdt_pkg::CNT_BITS_DEF
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic idle_i,
	output logic chip_reset_o,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_held;
		logic [11:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic run_en;
		logic restart;
		logic idle_en;
		logic [2:0] sel;
		logic seen;
		logic [4:0] rst_cnt;
		logic rst_out;
	} wdt_top_st_t;

	wdt_top_st_t st_ff;
	wdt_top_st_t nxt_st;
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [7:0] ctrl_rd;
	logic running;

	wdt_ctl_if ctl ();

	// word decode of a register bus address, shared by the write and read paths
	function automatic logic word_hit(input logic [11:0] addr, input logic [11:0] reg_addr);
		word_hit = (addr[11:2] == reg_addr[11:2]);
	endfunction : word_hit

	////////////////////////////////////////////////////////////////////////////
	// reset release

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_ff[1];

	////////////////////////////////////////////////////////////////////////////
	// counting stages

	assign running = st_ff.run_en && (!idle_i || st_ff.idle_en);
	assign ctl.run = running;
	assign ctl.clear = st_ff.restart || !st_ff.run_en || ctl.expire;
	assign ctl.sel = st_ff.sel;

	wdt_tick wdt_tick_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.ctl(ctl)
	);

	wdt_count #(
		.CNT_BITS(CNT_BITS)
	) wdt_count_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.ctl(ctl)
	);

	assign ctrl_rd = {st_ff.run_en, st_ff.restart, st_ff.idle_en, 2'b00, st_ff.sel};

	////////////////////////////////////////////////////////////////////////////
	// register bus and control state

	always_comb begin
		nxt_st = st_ff;
		// address and data channels are taken independently
		if (s_axi_awvalid && st_ff.awready) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_ff.wready) begin
			nxt_st.w_held = 1'b1;
			nxt_st.w_data = s_axi_wdata[7:0];
			nxt_st.w_lane0 = s_axi_wstrb[0];
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		nxt_st.restart = 1'b0;
		if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = wdt_pkg::RESP_OKAY;
			if (word_hit(st_ff.aw_addr, wdt_pkg::CTRL_ADDR)) begin
				if (st_ff.w_lane0) begin
					nxt_st.run_en = st_ff.w_data[wdt_pkg::RUN_EN_BIT];
					nxt_st.restart = st_ff.w_data[wdt_pkg::RESTART_BIT];
					nxt_st.idle_en = st_ff.w_data[wdt_pkg::IDLE_EN_BIT];
					nxt_st.sel = st_ff.w_data[wdt_pkg::SEL_LSB +: 3];
				end
			end else if (word_hit(st_ff.aw_addr, wdt_pkg::STAT_ADDR)) begin
				if (st_ff.w_lane0 && st_ff.w_data[wdt_pkg::SEEN_BIT]) begin
					nxt_st.seen = 1'b0;
				end
			end else begin
				nxt_st.bresp = wdt_pkg::RESP_DECERR;
			end
		end
		// expiry wins over a clear in the same cycle
		if (ctl.expire) begin
			nxt_st.seen = 1'b1;
		end
		nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;

		// read channel
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_ff.arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = wdt_pkg::RESP_OKAY;
			if (word_hit(s_axi_araddr, wdt_pkg::CTRL_ADDR)) begin
				nxt_st.rdata = {24'h000000, ctrl_rd};
			end else if (word_hit(s_axi_araddr, wdt_pkg::STAT_ADDR)) begin
				nxt_st.rdata = {30'h00000000, running, st_ff.seen};
			end else begin
				nxt_st.rdata = 32'h00000000;
				nxt_st.rresp = wdt_pkg::RESP_DECERR;
			end
		end
		nxt_st.arready = !nxt_st.rvalid;

		if (ctl.expire) begin
			nxt_st.rst_cnt = wdt_pkg::RST_HOLD;
		end else if (st_ff.rst_cnt != 5'h00) begin
			nxt_st.rst_cnt = st_ff.rst_cnt - 5'h01;
		end
		nxt_st.rst_out = nxt_st.rst_cnt != 5'h00;
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.awready <= 1'b1;
			st_ff.wready <= 1'b1;
			st_ff.arready <= 1'b1;
			st_ff.run_en <= wdt_pkg::CTRL_RESET[wdt_pkg::RUN_EN_BIT];
			st_ff.idle_en <= wdt_pkg::CTRL_RESET[wdt_pkg::IDLE_EN_BIT];
			st_ff.sel <= wdt_pkg::SEL_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign chip_reset_o = st_ff.rst_out;
	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready = st_ff.wready;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign s_axi_rvalid = st_ff.rvalid;
endmodule : wdt_top
`default_nettype wire

// file: dv/wdt_top_assertions.sv
// port assertions of the watchdog time-out reset block
`timescale 1ns/1ps
`default_nettype none
module wdt_top_checker #(
	parameter int unsigned CNT_BITS = wdt_pkg::CNT_BITS_DEF
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic idle_i,
	input wire logic chip_reset_o,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	localparam int MIN_P = (1 << CNT_BITS) * 24;
	logic wr, wr_ctl, clr, en_ff, ien_ff;
	int pc_ff, oc_ff, ic_ff, hc_ff;
	assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign wr_ctl = wr && s_axi_awaddr == wdt_pkg::CTRL_ADDR && s_axi_wstrb[0];
	// restart write, disable write or expiry start the period again
	assign clr = (wr_ctl && (s_axi_wdata[6] || !s_axi_wdata[7])) || (chip_reset_o && hc_ff == 0);
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_ff <= 1'b0;
			ien_ff <= 1'b0;
			pc_ff <= 0;
			oc_ff <= 0;
			ic_ff <= 0;
			hc_ff <= 0;
		end else begin
			if (wr_ctl) begin
				en_ff <= s_axi_wdata[7];
				ien_ff <= s_axi_wdata[5];
			end
			pc_ff <= clr ? 0 : pc_ff + 1;
			oc_ff <= en_ff ? 0 : oc_ff + 1;
			ic_ff <= (idle_i && !ien_ff) ? ic_ff + 1 : 0;
			hc_ff <= chip_reset_o ? hc_ff + 1 : 0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	AST_OFF_QUIET: assert property ($rose(chip_reset_o) |-> oc_ff < 8)
		else $error("chip reset raised while disabled");
	AST_IDLE_QUIET: assert property ($rose(chip_reset_o) |-> ic_ff < 8)
		else $error("chip reset raised in idle");
	AST_MIN_PERIOD: assert property ($rose(chip_reset_o) |-> pc_ff >= MIN_P)
		else $error("period shorter than minimum");
	AST_PULSE_WIDTH: assert property ($fell(chip_reset_o) |-> hc_ff == 24)
		else $error("chip reset pulse width wrong");
	AST_PULSE_HOLD: assert property ($rose(chip_reset_o) |=> chip_reset_o [*8])
		else $error("chip reset pulse too short");
	AST_WR_RESP: assert property (wr |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	cover property ($rose(chip_reset_o));
	cover property (wr_ctl && s_axi_wdata[6]);
	cover property (idle_i && !ien_ff && en_ff);
endmodule : wdt_top_checker
`default_nettype wire

// file: dv/tb_wdt_top.sv
// self-checking bench of the watchdog time-out reset block
`timescale 1ns/1ps
`default_nettype none
module tb_wdt_top;
	localparam int unsigned CNT_BITS = 2;
	localparam int UNIT = 12 << CNT_BITS;
	localparam logic [11:0] CA = wdt_pkg::CTRL_ADDR;
	localparam logic [11:0] SA = wdt_pkg::STAT_ADDR;
	logic clk_i, nrst_i, idle_i, chip_reset_o;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int n_errors, checked, cyc;
	int fct[8] = '{2, 8, 4, 16, 32, 64, 128, 256};
	wdt_top #(.CNT_BITS(CNT_BITS)) wdt_top_inst (.*);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic conclude;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : cmp
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// waits for the chip reset, checks its delay against f and its width
	task automatic per(input int f);
		int c;
		c = 0;
		while (chip_reset_o !== 1'b1) begin
			@(posedge clk_i);
			c++;
		end
		cmp("period", 32'h1, 32'(c >= UNIT * f - 2 && c <= UNIT * f + 6));
		c = 0;
		while (chip_reset_o === 1'b1) begin
			@(posedge clk_i);
			c++;
		end
		cmp("pulse width", 32'h18, 32'(c));
	endtask : per
	// watches n cycles and counts those with the chip reset high
	task automatic quiet(input string nm, input int n);
		int h;
		h = 0;
		repeat (n) begin
			@(posedge clk_i);
			if (chip_reset_o !== 1'b0) h++;
		end
		cmp(nm, 32'h0, 32'(h));
	endtask : quiet
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{cyc, n_errors, checked} = '0;
		{nrst_i, idle_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(CA);
		cmp("ctrl reset", 32'h0, d);
		rd(12'h004);
		cmp("unmapped rresp", 32'h3, 32'(r));
		wr(12'h004, 32'h80);
		cmp("unmapped bresp", 32'h3, 32'(r));
		wr(CA, 32'h7d);
		rd(CA);
		cmp("ctrl readback", 32'h25, d);
		for (int s = 0; s < 8; s++) begin
			wr(CA, 32'h80 | s);
			per(fct[s]);
			wr(CA, 32'h0);
		end
		wr(CA, 32'h80);
		repeat (60) @(posedge clk_i);
		wr(CA, 32'hc0);
		per(2);
		rd(SA);
		cmp("status after expiry", 32'h3, d);
		wr(SA, 32'h1);
		rd(SA);
		cmp("status after clear", 32'h2, d);
		repeat (30) @(posedge clk_i);
		wr(CA, 32'h0);
		quiet("quiet off", 300);
		wr(CA, 32'h80);
		per(2);
		wr(CA, 32'h0);
		idle_i <= 1'b1;
		wr(CA, 32'h80);
		quiet("quiet idle", 300);
		wr(CA, 32'ha0);
		per(2);
		// a second reset in mid-run puts the control register back to zero
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(CA);
		cmp("ctrl after reset", 32'h0, d);
		idle_i <= 1'b0;
		wr(CA, 32'h0);
		conclude();
	end
endmodule : tb_wdt_top
bind wdt_top wdt_top_checker #(.CNT_BITS(CNT_BITS)) chk_inst (.*);
`default_nettype wire
